/* logic/alu_status_flag_register.sv */
`include "alu_status_map.svh"
`default_nettype none

module alu_status_flag_register #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    // Execute stage
    input wire logic exValid,
    input wire alu_status_pkg::alu_op_e exOp,
    input wire alu_status_pkg::byte_t exA,
    input wire alu_status_pkg::byte_t exB,
    input wire logic [2:0] exBit,
    input wire logic exSrcIsStatus,
    input wire logic exDestIsStatus,
    output alu_status_pkg::byte_t resultData,
    output logic resultWe,
    output alu_status_pkg::byte_t statusOut,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import alu_status_pkg::*;

    logic [`FLAG_WIDTH-1:0] flags_reg, flags_next;
    byte_t resultData_reg;
    logic resultWe_reg;

    // ALU operand selection and flag generation
    wire byte_t flagByte = {3'b000, flags_reg};
    wire byte_t aOperand = exSrcIsStatus ? flagByte : exA;
    wire logic isAdd = (exOp == OP_ADD) || (exOp == OP_ADDC);
    wire logic isSub = (exOp == OP_SUB) || (exOp == OP_SUBB);
    wire logic isArith = isAdd || isSub;
    wire logic isLogic = (exOp == OP_AND) || (exOp == OP_IOR) || (exOp == OP_XOR);
    wire logic isClear = (exOp == OP_CLEAR);
    wire logic isDirect = (exOp == OP_BITSET) || (exOp == OP_BITCLR) || (exOp == OP_SWAP) || (exOp == OP_MOVE);
    wire logic affectsFlags = isArith || isLogic || isClear;

    // Subtract is add of the complement; carry-in 1 means no borrow pending
    wire byte_t addend = isSub ? ~exB : exB;
    wire logic carryIn = (exOp == OP_SUB) ? 1'b1 :
                         ((exOp == OP_ADDC) || (exOp == OP_SUBB)) ? flags_reg[`CARRY_POS] : 1'b0;
    wire logic [8:0] sum9 = {1'b0, aOperand} + {1'b0, addend} + {8'h00, carryIn};
    wire logic [4:0] half5 = {1'b0, aOperand[3:0]} + {1'b0, addend[3:0]} + {4'h0, carryIn};
    wire byte_t bitMask = 8'(8'h01 << exBit);

    byte_t aluResult;
    always_comb begin
        unique case (exOp)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: aluResult = sum9[7:0];
            OP_AND: aluResult = aOperand & exB;
            OP_IOR: aluResult = aOperand | exB;
            OP_XOR: aluResult = aOperand ^ exB;
            OP_BITSET: aluResult = aOperand | bitMask;
            OP_BITCLR: aluResult = aOperand & ~bitMask;
            OP_SWAP: aluResult = {aOperand[3:0], aOperand[7:4]};
            OP_MOVE: aluResult = exB;
            OP_NONE, OP_CLEAR: aluResult = 8'h00;
            default: aluResult = 8'h00;
        endcase
    end

    // Only the flags an op touches move; the rest keep their value
    wire logic wrapNew = (aOperand[7] == addend[7]) && (sum9[7] != aOperand[7]);
    wire logic [`FLAG_WIDTH-1:0] aluFlags = {
        (isArith || isLogic) ? aluResult[7] : flags_reg[`SIGN_POS],
        isArith ? wrapNew : flags_reg[`SIGNED_WRAP_POS],
        isClear ? 1'b1 : ((isArith || isLogic) ? (aluResult == 8'h00) : flags_reg[`ZERO_POS]),
        isArith ? half5[4] : flags_reg[`HALF_BORROW_POS],
        isArith ? sum9[8] : flags_reg[`CARRY_POS]
    };

    // Register bus, one write and one read in flight at most
    logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] awAddr_reg;
    logic [31:0] wData_reg, rdata_reg;
    logic [3:0] wStrb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake = s_axi_wvalid && s_axi_wready;
    wire logic haveAw = awHeld_reg || awTake;
    wire logic haveW = wHeld_reg || wTake;
    wire logic busWrite = haveAw && haveW && !bvalid_reg;
    wire logic [ADDR_W-1:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    wire logic [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
    wire logic [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    wire logic [7:0] wrWord = 8'({wrAddr[ADDR_W-1:2], 2'b00});
    wire logic wrFlagsHit = (wrWord == `FLAGS_OFFSET);
    wire logic wrMapped = wrFlagsHit || (wrWord == `LAST_RESULT_OFFSET);
    wire logic busFlagWrite = busWrite && wrFlagsHit && wrStrb[0];

    wire logic arTake = s_axi_arvalid && s_axi_arready;
    wire logic [7:0] rdWord = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
    wire logic rdFlagsHit = (rdWord == `FLAGS_OFFSET);
    wire logic rdResultHit = (rdWord == `LAST_RESULT_OFFSET);
    wire logic [31:0] rdValue = rdFlagsHit ? {24'h00_0000, flagByte} :
                                rdResultHit ? {24'h00_0000, resultData_reg} : 32'h0000_0000;

    assign s_axi_awready = !awHeld_reg && !bvalid_reg;
    assign s_axi_wready = !wHeld_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Execute stage wins a same-cycle collision so the instruction stream stays exact
    always_comb begin
        flags_next = flags_reg;
        if (exValid && exDestIsStatus && isDirect) begin
            flags_next = aluResult[`FLAG_WIDTH-1:0];
        end else if (exValid && affectsFlags) begin
            flags_next = aluFlags;
        end else if (busFlagWrite) begin
            flags_next = wrData[`FLAG_WIDTH-1:0];
        end
    end

    // Results aimed at the status register never reach the file
    wire logic writeFile = exValid && (exOp != OP_NONE) && !exDestIsStatus;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_reg <= `FLAGS_RESET;
            resultData_reg <= `LAST_RESULT_RESET;
            resultWe_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            resultWe_reg <= writeFile;
            if (writeFile) begin
                resultData_reg <= aluResult;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            awAddr_reg <= '0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else begin
            if (awTake && !busWrite) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake && !busWrite) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (busWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end else if (arTake) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdValue;
            rresp_reg <= (rdFlagsHit || rdResultHit) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign resultData = resultData_reg;
    assign resultWe = resultWe_reg;
    assign statusOut = flagByte;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_statusRead;
        arTake && rdFlagsHit;
    endsequence

    sequence s_readAnswer;
        s_axi_rvalid && s_axi_rdata[7:0] == $past(flagByte) && s_axi_rresp == `RESP_OKAY;
    endsequence

    a_flags_hold_idle: assert property (
        !exValid && !busWrite |=> $stable(flags_reg))
        else $error("Flags moved with no instruction or bus write");

    a_status_read_back: assert property (s_statusRead |=> s_readAnswer)
        else $error("Status read returned wrong data");

    a_flag_dest_discard: assert property (
        exValid && exDestIsStatus && affectsFlags |=> !resultWe && flags_reg == $past(aluFlags))
        else $error("Flag op on status leaked its result");

    a_file_dest_write: assert property (
        exValid && !exDestIsStatus && exOp != OP_NONE |=> resultWe && resultData == $past(aluResult))
        else $error("Result not written to file");

    a_clear_sets_zero: assert property (
        exValid && exOp == OP_CLEAR && exDestIsStatus
        |=> flags_reg == ($past(flags_reg) | 5'h04))
        else $error("Clear on status did not give zero-only change");

    a_direct_status_write: assert property (
        exValid && exDestIsStatus && isDirect
        |=> flags_reg == $past(aluResult[4:0]) && !resultWe)
        else $error("Direct write to status lost");

    a_sub_carry_borrow: assert property (
        exValid && exOp == OP_SUB && !exSrcIsStatus
        |=> flags_reg[`CARRY_POS] == $past(exA >= exB)
            && flags_reg[`HALF_BORROW_POS] == $past(exA[3:0] >= exB[3:0]))
        else $error("Subtract carry is not inverted borrow");

    a_upper_bits_zero: assert property (
        s_statusRead |=> s_axi_rdata[31:5] == 27'h000_0000)
        else $error("Unimplemented status bits not zero");

    sequence s_writeDone;
        s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endsequence

    a_write_answer: assert property (
        busWrite |=> s_writeDone)
        else $error("Write was not answered");

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write answer dropped before taken");

    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("Read answer dropped before taken");

    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("Second read accepted while one is open");

    a_bus_flag_write: assert property (
        busFlagWrite && !exValid |=> flags_reg == $past(wrData[`FLAG_WIDTH-1:0]))
        else $error("Bus write to flags lost");

    a_result_idle: assert property (
        !exValid |=> !resultWe)
        else $error("File write with no instruction");

    a_logic_keeps: assert property (
        exValid && isLogic
        |=> flags_reg[`SIGNED_WRAP_POS] == $past(flags_reg[`SIGNED_WRAP_POS])
            && flags_reg[`HALF_BORROW_POS:`CARRY_POS] == $past(flags_reg[`HALF_BORROW_POS:`CARRY_POS]))
        else $error("Logic op changed arithmetic flags");

    a_add_carry_zero: assert property (
        exValid && exOp == OP_ADD && !exSrcIsStatus
        |=> flags_reg[`CARRY_POS] == $past({1'b0, exA} + {1'b0, exB} > 9'h0FF)
            && flags_reg[`ZERO_POS] == $past(8'(exA + exB) == 8'h00))
        else $error("Add carry or zero flag wrong");

    a_none_ignored: assert property (
        exValid && exOp == OP_NONE && !busWrite |=> $stable(flags_reg) && !resultWe)
        else $error("Idle op changed state");

    a_sub_zero: assert property (
        exValid && exOp == OP_SUB && !exSrcIsStatus |=> flags_reg[`ZERO_POS] == $past(exA == exB))
        else $error("Subtract zero flag wrong");

endmodule

`default_nettype wire

/* logic/alu_status_map.svh */
`ifndef ALU_STATUS_MAP_SVH
`define ALU_STATUS_MAP_SVH

// Register byte addresses on the AXI4-Lite slave
`define FLAGS_OFFSET 8'h00
`define LAST_RESULT_OFFSET 8'h04

// Flag positions inside the status byte
`define CARRY_POS 0
`define HALF_BORROW_POS 1
`define ZERO_POS 2
`define SIGNED_WRAP_POS 3
`define SIGN_POS 4
`define FLAG_WIDTH 5

// Reset values
`define FLAGS_RESET 5'h00
`define LAST_RESULT_RESET 8'h00

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/alu_status_pkg.sv */
`default_nettype none

package alu_status_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_ADDC,
        OP_SUB,
        OP_SUBB,
        OP_AND,
        OP_IOR,
        OP_XOR,
        OP_CLEAR,
        OP_BITSET,
        OP_BITCLR,
        OP_SWAP,
        OP_MOVE
    } alu_op_e;

    typedef logic [7:0] byte_t;

endpackage

`default_nettype wire

/* verif/exec_stage_model.sv */
`default_nettype none
module exec_stage_model (
    input wire logic clk,
    output logic exValid,
    output alu_status_pkg::alu_op_e exOp,
    output alu_status_pkg::byte_t exA,
    output alu_status_pkg::byte_t exB,
    output logic [2:0] exBit,
    output logic exSrcIsStatus,
    output logic exDestIsStatus
);
    timeunit 1ns;
    timeprecision 100ps;
    import alu_status_pkg::*;
    initial begin
        exOp = OP_NONE;
        {exValid, exA, exB, exBit, exSrcIsStatus, exDestIsStatus} = '0;
    end
    // Valid drops after the taking edge, so each call is exactly one instruction
    task automatic issue(input alu_op_e o, input byte_t a, input byte_t b, input logic [2:0] n, input logic [1:0] sd);
        @(posedge clk);
        exOp <= o;
        {exValid, exA, exB, exBit, exSrcIsStatus, exDestIsStatus} <= {1'b1, a, b, n, sd};
        @(posedge clk);
        exValid <= 1'b0;
        exOp <= OP_NONE;
    endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`include "alu_status_map.svh"
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import alu_status_pkg::*;
    logic clk, sys_rst, exValid, exSrcIsStatus, exDestIsStatus, resultWe;
    alu_op_e exOp;
    byte_t exA, exB, resultData, statusOut;
    logic [2:0] exBit;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors = 0;
    int checked = 0;
    exec_stage_model exec_stage_model_inst (.clk, .exValid, .exOp, .exA, .exB, .exBit, .exSrcIsStatus,
        .exDestIsStatus);
    alu_status_flag_register alu_status_flag_register_inst (.clk, .sys_rst, .exValid, .exOp, .exA, .exB,
        .exBit, .exSrcIsStatus, .exDestIsStatus, .resultData, .resultWe, .statusOut, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Ready is looked at mid-cycle; it cannot change before the next rising edge
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        logic aw, w, b;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} <= {ad, d, st, 2'b11};
        {aw, w, b} = 3'b110;
        while (aw || w) begin
            @(negedge clk);
            {aw, w} = {aw && !s_axi_awready, w && !s_axi_wready};
            @(posedge clk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, !(aw || w)};
        end
        while (!b) begin
            @(negedge clk);
            {b, r} = {s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        logic a, v;
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid} <= {ad, 1'b1};
        {a, v} = 2'b10;
        while (a) begin
            @(negedge clk);
            a = !s_axi_arready;
            @(posedge clk);
            {s_axi_arvalid, s_axi_rready} <= {a, !a};
        end
        while (!v) begin
            @(negedge clk);
            {v, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(input alu_op_e o, input byte_t a, input byte_t b, input logic [2:0] n, input logic [1:0] sd,
        input logic we, input byte_t res, input byte_t st);
        exec_stage_model_inst.issue(o, a, b, n, sd);
        #1;
        `CHK("resultWe", we, resultWe)
        if (we) `CHK("resultData", res, resultData)
        `CHK("statusOut", st, statusOut)
    endtask
    initial begin
        #(25 * 3000);
        n_errors++;
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        axr(`FLAGS_OFFSET, rd, rs);
        `CHK("flags", 32'h0000_0000, rd)
        run(OP_SUB, 8'h05, 8'h03, 3'h0, 2'b00, 1'b1, 8'h02, 8'h03);
        run(OP_SUB, 8'h03, 8'h05, 3'h0, 2'b00, 1'b1, 8'hFE, 8'h10);
        run(OP_ADD, 8'h7F, 8'h01, 3'h0, 2'b00, 1'b1, 8'h80, 8'h1A);
        run(OP_ADD, 8'h80, 8'h80, 3'h0, 2'b01, 1'b0, 8'h00, 8'h0D);
        run(OP_ADD, 8'h7F, 8'h01, 3'h0, 2'b01, 1'b0, 8'h00, 8'h1A);
        run(OP_CLEAR, 8'h5A, 8'h00, 3'h0, 2'b01, 1'b0, 8'h00, 8'h1E);
        run(OP_BITCLR, 8'h00, 8'h00, 3'h4, 2'b11, 1'b0, 8'h00, 8'h0E);
        run(OP_BITSET, 8'h00, 8'h00, 3'h7, 2'b11, 1'b0, 8'h00, 8'h0E);
        run(OP_SWAP, 8'h00, 8'h00, 3'h0, 2'b11, 1'b0, 8'h00, 8'h00);
        run(OP_MOVE, 8'h00, 8'h15, 3'h0, 2'b01, 1'b0, 8'h00, 8'h15);
        run(OP_ADDC, 8'h01, 8'h01, 3'h0, 2'b00, 1'b1, 8'h03, 8'h00);
        run(OP_SUBB, 8'h05, 8'h03, 3'h0, 2'b00, 1'b1, 8'h01, 8'h03);
        run(OP_CLEAR, 8'h5A, 8'h00, 3'h0, 2'b00, 1'b1, 8'h00, 8'h07);
        run(OP_XOR, 8'h80, 8'h01, 3'h0, 2'b00, 1'b1, 8'h81, 8'h13);
        run(OP_IOR, 8'h00, 8'h00, 3'h0, 2'b01, 1'b0, 8'h00, 8'h07);
        run(OP_AND, 8'hC3, 8'h81, 3'h0, 2'b00, 1'b1, 8'h81, 8'h13);
        run(OP_NONE, 8'h12, 8'h34, 3'h0, 2'b00, 1'b0, 8'h00, 8'h13);
        axw(`FLAGS_OFFSET, 32'hFFFF_FFFF, 4'hF, rs);
        `CHK("wresp", `RESP_OKAY, rs)
        `CHK("statusOut", 8'h1F, statusOut)
        axw(`FLAGS_OFFSET, 32'h0000_0000, 4'h0, rs);
        `CHK("wresp", `RESP_OKAY, rs)
        axr(`FLAGS_OFFSET, rd, rs);
        `CHK("flags", 32'h0000_001F, rd)
        run(OP_ADD, 8'hAA, 8'h01, 3'h0, 2'b10, 1'b1, 8'h20, 8'h02);
        axw(`LAST_RESULT_OFFSET, 32'h0000_0055, 4'hF, rs);
        `CHK("wresp", `RESP_OKAY, rs)
        axr(`LAST_RESULT_OFFSET, rd, rs);
        `CHK("result", 32'h0000_0020, rd)
        axr(8'h08, rd, rs);
        `CHK("rresp", `RESP_SLVERR, rs)
        `CHK("rdata", 32'h0000_0000, rd)
        axw(8'h0C, 32'h0000_0001, 4'hF, rs);
        `CHK("wresp", `RESP_SLVERR, rs)
        // Second reset in mid-run must bring flags and last result back to zero
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        axr(`LAST_RESULT_OFFSET, rd, rs);
        `CHK("result", 32'h0000_0000, rd)
        `CHK("statusOut", 8'h00, statusOut)
        final_report();
    end
endmodule
`undef CHK
`default_nettype wire
